// ===== verilog/uoc_pkg.sv
package uoc_pkg;

  // ==========================================================
  // register map (byte offsets)
  localparam logic [7:0] UOC_CTRL_OFS   = 8'h00;
  localparam logic [7:0] UOC_COUNT_OFS  = 8'h04;
  localparam logic [7:0] UOC_STATUS_OFS = 8'h08;
  localparam logic [7:0] UOC_SENSE_OFS  = 8'h0C;
  localparam logic [7:0] UOC_CRC_OFS    = 8'h10;

  // ==========================================================
  // control register fields
  localparam int UOC_CTRL_GO_BIT     = 0;
  localparam int UOC_CTRL_START_BIT  = 1;
  localparam int UOC_CTRL_FINISH_BIT = 2;
  localparam int UOC_CTRL_TERM_BIT   = 3;
  localparam int UOC_CTRL_FAST_BIT   = 4;
  localparam int UOC_CTRL_KIND_LSB   = 5;
  localparam int UOC_CTRL_ABORT_BIT  = 7;

  // status register fields
  localparam int UOC_ST_BUSY_BIT  = 0;
  localparam int UOC_ST_DONE_BIT  = 1;
  localparam int UOC_ST_CRCE_BIT  = 2;
  localparam int UOC_ST_OVR_BIT   = 3;
  localparam int UOC_ST_ABT_BIT   = 4;
  localparam int UOC_ST_ERR_LSB   = 8;
  localparam int UOC_ST_CHK_BIT   = 16;

  // sense register fields
  localparam int UOC_SN_KEY_LSB  = 0;
  localparam int UOC_SN_ASC_LSB  = 8;
  localparam int UOC_SN_ASCQ_LSB = 16;

  // ==========================================================
  // error and sense codes
  localparam int         UOC_ERR_ICRC_BIT  = 7;
  localparam int         UOC_ERR_ABRT_BIT  = 2;
  localparam logic [3:0] UOC_KEY_ABORTED   = 4'hB;
  localparam logic [3:0] UOC_KEY_HARDWARE  = 4'h4;
  localparam logic [7:0] UOC_ASC_CRC       = 8'h08;
  localparam logic [7:0] UOC_ASCQ_CRC      = 8'h03;

  // ==========================================================
  // crc and extra words
  localparam logic [15:0] UOC_CRC_SEED    = 16'h4ABA;
  localparam logic [1:0]  UOC_EXTRA_SLOW  = 2'h2;
  localparam logic [1:0]  UOC_EXTRA_FAST  = 2'h3;

  // ==========================================================
  // timing
  localparam int         UOC_CLK_NS   = 10;
  localparam int         UOC_T_RP_NS  = 160;
  localparam logic [7:0] UOC_T_RP_CYC =
    8'((UOC_T_RP_NS + UOC_CLK_NS - 1) / UOC_CLK_NS);

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    UOC_KIND_DMA   = 2'b00,
    UOC_KIND_SENSE = 2'b01,
    UOC_KIND_PKT   = 2'b10,
    UOC_KIND_RSVD  = 2'b11
  } uoc_kind_e;

  typedef enum logic [2:0] {
    UOC_IDLE  = 3'b000,
    UOC_REQ   = 3'b001,
    UOC_XFER  = 3'b010,
    UOC_DTERM = 3'b011,
    UOC_TERM  = 3'b100
  } uoc_fsm_e;

endpackage

// ===== verilog/uoc_crc_next.sv
`timescale 1ns/1ps
module uoc_crc_next
  import uoc_pkg::*;
(
  input  wire logic [15:0] crc_state_current_in,
  input  wire logic [15:0] data_in,
  output logic      [15:0] crc_state_next_out
);

  // ==========================================================
  // feedback terms
  logic [16:1] fb;

  genvar i;
  generate
    // RL22 feedback terms
    for (i = 1; i <= 16; i++) begin : g_fb
      if (i >= 12) begin : g_hi
        assign fb[i] = data_in[i-1] ^ crc_state_current_in[16-i] ^
                       fb[i-4] ^ fb[i-11];
      end else if (i >= 5) begin : g_mid
        assign fb[i] = data_in[i-1] ^ crc_state_current_in[16-i] ^
                       fb[i-4];
      end else begin : g_lo
        assign fb[i] = data_in[i-1] ^ crc_state_current_in[16-i];
      end
    end
    // RL21 next state bits
    for (i = 0; i < 16; i++) begin : g_nx
      if (i >= 12) begin : g_hi
        assign crc_state_next_out[i] = fb[16-i] ^ fb[21-i] ^ fb[28-i];
      end else if (i >= 5) begin : g_mid
        assign crc_state_next_out[i] = fb[16-i] ^ fb[21-i];
      end else begin : g_lo
        assign crc_state_next_out[i] = fb[16-i];
      end
    end
  endgenerate

endmodule

// ===== verilog/uoc_dev.sv
// Functional notes
// RL1: host ends burst by stopping strobe edges, then asserts stop.
// RL2: on host stop, drop dmarq quickly and keep it low.
// RL3: in host termination, negate ddmardy and hold it negated.
// RL4: the strobe rise after dmarq drops carries no data; ignore it.
// RL5: host drives its crc and then negates dmack.
// RL6: capture host crc at dmack negation, compare with own crc.
// RL7: release ddmardy promptly once dmack is negated.
// RL8: report command completion only after any burst has ended; a go pending with finish in idle starts its burst as done is set.
// RL9: device termination only after one word, by negating ddmardy.
// RL10: accept two extra words in slow modes, three in fast.
// RL11: drop dmarq at least trp after ddmardy; rearm after dmack.
// RL12: host asserts stop after device drops dmarq.
// RL13: crc register loads 4ABA at each burst start.
// RL14: crc updates once per data strobe edge only.
// RL15: keep first crc error of a command; later bursts never clear.
// RL16: after a crc error either finish or abort; report both ways.
// RL17: dma commands report icrc bit7 and abrt bit2.
// RL18: sense transfer error: chk, key 0Bh, sense data kept.
// RL19: other packet error: chk, key 04h, asc/ascq 08h/03h.
// RL20: end burst when command data is in; discard surplus words.
// RL21: polynomial x16+x12+x5+1, word at a time, bit 0 first.
// RL22: next crc from parallel feedback terms.
// RL23: a new command clears the saved crc error.
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module uoc_dev
  import uoc_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        srst_in,
  input  wire logic        ce_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        dmack_n_in,
  input  wire logic        stop_in,
  input  wire logic        hstrobe_in,
  input  wire logic [15:0] dd_in,
  output logic             dmarq_out,
  output logic             ddmardy_n_out,
  output logic             ddmardy_oe_out,
  output logic      [15:0] wdata_out,
  output logic             wvalid_out,
  output logic             cmd_done_out
);

  // ==========================================================
  // state
  typedef struct packed {
    uoc_fsm_e    fsm;
    logic [2:0]  hs_sync;
    logic [2:0]  ack_sync;
    logic [1:0]  stop_sync;
    logic [15:0] dd_s1;
    logic [15:0] dd_s2;
    logic [15:0] crc;
    logic [15:0] host_crc;
    logic        dmarq;
    logic        rdy_n;
    logic        rdy_oe;
    logic [15:0] words_left;
    logic [15:0] burst_words;
    logic [1:0]  extra;
    logic [7:0]  tmr;
    logic        go_pend;
    logic        term_pend;
    logic        fin_pend;
    logic        fast;
    uoc_kind_e   kind;
    logic        abort_en;
    logic        crc_err;
    logic        overrun;
    logic        aborted;
    logic        done;
    logic [7:0]  err_reg;
    logic        chk;
    logic [3:0]  key;
    logic [7:0]  asc;
    logic [7:0]  ascq;
    logic [15:0] wdata;
    logic        wvalid;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } uoc_state_s;

  uoc_state_s st_r;
  uoc_state_s st_nxt;

  logic [15:0] crc_calc;

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == UOC_CTRL_OFS) || (a == UOC_COUNT_OFS) ||
                 (a == UOC_STATUS_OFS) || (a == UOC_SENSE_OFS) ||
                 (a == UOC_CRC_OFS);
  endfunction

  uoc_crc_next u_crc (
    .crc_state_current_in (st_r.crc),
    .data_in              (st_r.dd_s2),
    .crc_state_next_out   (crc_calc)
  );

  // ==========================================================
  // next state
  logic        hs_edge;
  logic        ack_rise;
  logic        stop_s;
  logic        data_edge;
  logic        wr_go;
  logic [31:0] rd_word;
  logic [1:0]  extra_max;

  always_comb begin
    st_nxt   = st_r;
    hs_edge  = st_r.hs_sync[1] ^ st_r.hs_sync[2];
    ack_rise = st_r.ack_sync[1] & ~st_r.ack_sync[2];
    stop_s   = st_r.stop_sync[1];
    extra_max = st_r.fast ? UOC_EXTRA_FAST : UOC_EXTRA_SLOW;
    st_nxt.wvalid = 1'b0;

    // link pins pass two flops before anything reads them
    st_nxt.hs_sync   = {st_r.hs_sync[1:0], hstrobe_in};
    st_nxt.ack_sync  = {st_r.ack_sync[1:0], dmack_n_in};
    st_nxt.stop_sync = {st_r.stop_sync[0], stop_in};
    st_nxt.dd_s1     = dd_in;
    st_nxt.dd_s2     = st_r.dd_s1;

    // RL14 only edges inside the data phase count
    data_edge = hs_edge &&
                (st_r.fsm == UOC_XFER || st_r.fsm == UOC_DTERM);

    // ---------------- apb slave ----------------
    wr_go = psel_in & penable_in & st_r.pready & pwrite_in;
    if (psel_in && penable_in && !st_r.pready) begin
      st_nxt.pready  = 1'b1;
      st_nxt.pslverr = ~addr_known(paddr_in);
      rd_word = 32'h0000_0000;
      unique case (paddr_in)
        UOC_CTRL_OFS: begin
          rd_word[UOC_CTRL_FAST_BIT]  = st_r.fast;
          rd_word[UOC_CTRL_KIND_LSB +: 2] = st_r.kind;
          rd_word[UOC_CTRL_ABORT_BIT] = st_r.abort_en;
        end
        UOC_COUNT_OFS:  rd_word[15:0] = st_r.words_left;
        UOC_STATUS_OFS: begin
          rd_word[UOC_ST_BUSY_BIT] = (st_r.fsm != UOC_IDLE);
          rd_word[UOC_ST_DONE_BIT] = st_r.done;
          rd_word[UOC_ST_CRCE_BIT] = st_r.crc_err;
          rd_word[UOC_ST_OVR_BIT]  = st_r.overrun;
          rd_word[UOC_ST_ABT_BIT]  = st_r.aborted;
          rd_word[UOC_ST_ERR_LSB +: 8] = st_r.err_reg;
          rd_word[UOC_ST_CHK_BIT]  = st_r.chk;
        end
        UOC_SENSE_OFS: begin
          rd_word[UOC_SN_KEY_LSB +: 4]  = st_r.key;
          rd_word[UOC_SN_ASC_LSB +: 8]  = st_r.asc;
          rd_word[UOC_SN_ASCQ_LSB +: 8] = st_r.ascq;
        end
        UOC_CRC_OFS: rd_word = {st_r.host_crc, st_r.crc};
        default:     rd_word = 32'h0000_0000;
      endcase
      st_nxt.prdata = pwrite_in ? 32'h0000_0000 : rd_word;
    end else begin
      rd_word = 32'h0000_0000;
      st_nxt.pready  = 1'b0;
      st_nxt.pslverr = 1'b0;
    end

    if (wr_go) begin
      unique case (paddr_in)
        UOC_CTRL_OFS: begin
          st_nxt.fast     = pwdata_in[UOC_CTRL_FAST_BIT];
          st_nxt.kind     = uoc_kind_e'(pwdata_in[UOC_CTRL_KIND_LSB +: 2]);
          st_nxt.abort_en = pwdata_in[UOC_CTRL_ABORT_BIT];
          if (pwdata_in[UOC_CTRL_GO_BIT]) begin
            st_nxt.go_pend = 1'b1;
          end
          if (pwdata_in[UOC_CTRL_TERM_BIT]) begin
            st_nxt.term_pend = 1'b1;
          end
          if (pwdata_in[UOC_CTRL_FINISH_BIT]) begin
            st_nxt.fin_pend = 1'b1;
          end
          // RL23 new command clears errors
          if (pwdata_in[UOC_CTRL_START_BIT]) begin
            st_nxt.crc_err  = 1'b0;
            st_nxt.overrun  = 1'b0;
            st_nxt.aborted  = 1'b0;
            st_nxt.done     = 1'b0;
            st_nxt.err_reg  = 8'h00;
            st_nxt.chk      = 1'b0;
            st_nxt.fin_pend = 1'b0;
          end
        end
        UOC_COUNT_OFS: st_nxt.words_left = pwdata_in[15:0];
        UOC_SENSE_OFS: begin
          st_nxt.key  = pwdata_in[UOC_SN_KEY_LSB +: 4];
          st_nxt.asc  = pwdata_in[UOC_SN_ASC_LSB +: 8];
          st_nxt.ascq = pwdata_in[UOC_SN_ASCQ_LSB +: 8];
        end
        default: st_nxt.err_reg = st_r.err_reg;
      endcase
    end

    // ---------------- data words ----------------
    if (data_edge) begin
      // RL14 one update per data edge
      st_nxt.crc = crc_calc;
      st_nxt.burst_words = st_r.burst_words + 16'h0001;
      // RL20 surplus words feed the crc but are dropped
      if (st_r.words_left != 16'h0000 && !st_r.aborted) begin
        st_nxt.words_left = st_r.words_left - 16'h0001;
        st_nxt.wdata  = st_r.dd_s2;
        st_nxt.wvalid = 1'b1;
      end
      // RL10 extra words after ddmardy negation
      if (st_r.fsm == UOC_DTERM) begin
        if (st_r.extra == extra_max) begin
          st_nxt.overrun = 1'b1;
        end else begin
          st_nxt.extra = st_r.extra + 2'h1;
        end
      end
    end

    // ---------------- burst sequencer ----------------
    unique case (st_r.fsm)
      UOC_IDLE: begin
        st_nxt.rdy_oe = 1'b0;
        st_nxt.rdy_n  = 1'b1;
        // RL11 rearm only while dmack is negated
        if (st_r.go_pend && st_r.ack_sync[1] &&
            st_r.words_left != 16'h0000 && !st_r.aborted) begin
          st_nxt.go_pend = 1'b0;
          st_nxt.dmarq   = 1'b1;
          // RL13 seed before any data moves
          st_nxt.crc         = UOC_CRC_SEED;
          st_nxt.burst_words = 16'h0000;
          st_nxt.extra       = 2'h0;
          st_nxt.term_pend   = 1'b0;
          st_nxt.fsm         = UOC_REQ;
        end
      end
      UOC_REQ: begin
        if (!st_r.ack_sync[1]) begin
          st_nxt.rdy_oe = 1'b1;
          if (!stop_s) begin
            st_nxt.rdy_n = 1'b0;
            st_nxt.fsm   = UOC_XFER;
          end
        end
      end
      UOC_XFER: begin
        if (stop_s && st_r.burst_words != 16'h0000) begin
          // RL2 drop dmarq on host stop
          st_nxt.dmarq = 1'b0;
          // RL3 ddmardy negated until the end
          st_nxt.rdy_n = 1'b1;
          st_nxt.fsm   = UOC_TERM;
        end else if (st_r.burst_words != 16'h0000 &&
                     (st_r.term_pend || st_r.words_left == 16'h0000 ||
                      st_r.aborted)) begin
          // RL9 device termination by ddmardy
          st_nxt.rdy_n     = 1'b1;
          st_nxt.term_pend = 1'b0;
          st_nxt.tmr       = UOC_T_RP_CYC;
          st_nxt.fsm       = UOC_DTERM;
        end
      end
      UOC_DTERM: begin
        // RL11 dmarq held until trp has passed
        if (st_r.tmr > 8'h01) begin
          st_nxt.tmr = st_r.tmr - 8'h01;
        end else begin
          st_nxt.tmr   = 8'h00;
          st_nxt.dmarq = 1'b0;
          st_nxt.fsm   = UOC_TERM;
        end
      end
      UOC_TERM: begin
        // RL4 strobe activity here is never data
        if (ack_rise) begin
          // RL6 latch and compare host crc
          st_nxt.host_crc = st_r.dd_s2;
          // RL7 release ddmardy
          st_nxt.rdy_oe = 1'b0;
          st_nxt.rdy_n  = 1'b1;
          st_nxt.fsm    = UOC_IDLE;
          // RL15 only the first error is kept
          if (st_r.dd_s2 != st_r.crc && !st_r.crc_err) begin
            st_nxt.crc_err = 1'b1;
            // RL16 optional abort, error reported either way
            if (st_r.abort_en) begin
              st_nxt.aborted  = 1'b1;
              st_nxt.fin_pend = 1'b1;
            end
            unique case (st_r.kind)
              UOC_KIND_SENSE: begin
                // RL18 aborted key, sense data kept
                st_nxt.chk = 1'b1;
                st_nxt.key = UOC_KEY_ABORTED;
              end
              UOC_KIND_PKT: begin
                // RL19 hardware key with crc codes
                st_nxt.chk  = 1'b1;
                st_nxt.key  = UOC_KEY_HARDWARE;
                st_nxt.asc  = UOC_ASC_CRC;
                st_nxt.ascq = UOC_ASCQ_CRC;
              end
              default: begin
                // RL17 icrc and abrt
                st_nxt.err_reg[UOC_ERR_ICRC_BIT] = 1'b1;
                st_nxt.err_reg[UOC_ERR_ABRT_BIT] = 1'b1;
              end
            endcase
          end
        end
      end
      default: begin
        st_nxt.fsm    = UOC_IDLE;
        st_nxt.dmarq  = 1'b0;
        st_nxt.rdy_oe = 1'b0;
      end
    endcase

    // RL8 completion waits for idle with dmack negated; a go pending in the same cycle still starts its burst
    if (st_r.fin_pend && st_r.fsm == UOC_IDLE && st_r.ack_sync[1] &&
        !(wr_go && paddr_in == UOC_CTRL_OFS &&
          pwdata_in[UOC_CTRL_START_BIT])) begin
      st_nxt.fin_pend = 1'b0;
      st_nxt.done     = 1'b1;
      st_nxt.go_pend  = 1'b0;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      st_r          <= '0;
      st_r.fsm      <= UOC_IDLE;
      st_r.kind     <= UOC_KIND_DMA;
      st_r.hs_sync  <= 3'h7;
      st_r.ack_sync <= 3'h7;
      st_r.rdy_n    <= 1'b1;
      st_r.crc      <= UOC_CRC_SEED;
    end else if (ce_in) begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs, all straight from flops
  assign prdata_out     = st_r.prdata;
  assign pready_out     = st_r.pready;
  assign pslverr_out    = st_r.pslverr;
  assign dmarq_out      = st_r.dmarq;
  assign ddmardy_n_out  = st_r.rdy_n;
  assign ddmardy_oe_out = st_r.rdy_oe;
  assign wdata_out      = st_r.wdata;
  assign wvalid_out     = st_r.wvalid;
  assign cmd_done_out   = st_r.done;

endmodule

// ===== verification/uoc_host_model.sv
`timescale 1ns/1ps
module uoc_host_model
  import uoc_pkg::*;
(
  input  wire logic        lclk_in,
  input  wire logic        dmarq_in,
  input  wire logic        ddmardy_n_in,
  output logic             dmack_n_out,
  output logic             stop_out,
  output logic             hstrobe_out,
  output logic      [15:0] dd_out
);
  logic [15:0] crc_q;

  // ======
  // crc
  // parallel word update
  function automatic logic [15:0] cnx(logic [15:0] c, logic [15:0] d);
    logic [16:1] f;
    logic [15:0] n;
    for (int i = 1; i <= 16; i++) begin
      f[i] = d[i-1] ^ c[16-i];
      if (i > 4) f[i] = f[i] ^ f[i-4];
      if (i > 11) f[i] = f[i] ^ f[i-11];
    end
    for (int i = 0; i < 16; i++) begin
      n[i] = f[16-i];
      if (i > 4) n[i] = n[i] ^ f[21-i];
      if (i > 11) n[i] = n[i] ^ f[28-i];
    end
    return n;
  endfunction

  initial begin
    dmack_n_out = 1'b1;
    stop_out = 1'b0;
    hstrobe_out = 1'b1;
    dd_out = 16'hFFFF;
    crc_q = UOC_CRC_SEED;
  end

  // ======
  // one data-out burst
  task automatic burst(input int nw, input bit ht, input bit bad,
                       input logic [15:0] b);
    bit late;
    late = 1'b0;
    crc_q = UOC_CRC_SEED;
    wait (dmarq_in === 1'b1);
    @(posedge lclk_in);
    stop_out <= 1'b1;
    @(posedge lclk_in);
    dmack_n_out <= 1'b0;
    @(posedge lclk_in);
    stop_out <= 1'b0;
    wait (ddmardy_n_in === 1'b0);
    for (int i = 0; i < nw; i++) begin
      @(posedge lclk_in);
      if (!ht && late) break;
      late = (ddmardy_n_in === 1'b1);
      dd_out <= b + 16'(i);
      crc_q = cnx(crc_q, b + 16'(i));
      @(negedge lclk_in);
      hstrobe_out <= ~hstrobe_out;
    end
    if (ht) begin
      @(posedge lclk_in);
      stop_out <= 1'b1;
    end
    wait (dmarq_in === 1'b0);
    @(posedge lclk_in);
    stop_out <= 1'b1;
    hstrobe_out <= 1'b1;
    dd_out <= crc_q ^ {15'h0000, bad};
    repeat (2) @(posedge lclk_in);
    dmack_n_out <= 1'b1;
    @(posedge lclk_in);
    stop_out <= 1'b0;
    dd_out <= ~dd_out;
  endtask
endmodule

// ===== verification/uoc_dev_assertions.sv
`timescale 1ns/1ps
module uoc_dev_chk
  import uoc_pkg::*;
(
  input  wire logic core_clk_in,
  input  wire logic srst_in,
  input  wire logic dmack_n_in,
  input  wire logic stop_in,
  input  wire logic dmarq_out,
  input  wire logic ddmardy_n_out,
  input  wire logic ddmardy_oe_out,
  input  wire logic wvalid_out,
  input  wire logic cmd_done_out
);
  logic [7:0] hi_cnt_r;
  logic [7:0] hi_cnt_nxt;

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  // ======
  // cycles with ready negated inside a burst
  always_comb begin
    hi_cnt_nxt = 8'h00;
    if (ddmardy_n_out && !dmack_n_in) begin
      hi_cnt_nxt = (hi_cnt_r == 8'hFF) ? 8'hFF : hi_cnt_r + 8'h01;
    end
  end
  always_ff @(posedge core_clk_in) begin
    hi_cnt_r <= srst_in ? 8'h00 : hi_cnt_nxt;
  end

  // ======
  // link
  a_stop_drops_rq: assert property (
    $rose(stop_in) && !dmack_n_in && dmarq_out |-> ##[1:6] !dmarq_out)
    else $error("dmarq kept after stop");
  a_rq_stays_low: assert property (
    !dmarq_out && !dmack_n_in |=> !dmarq_out)
    else $error("dmarq raised before dmack end");
  a_rdy_on_stop: assert property (
    $rose(stop_in) && !dmack_n_in && ddmardy_oe_out
      |-> ##[1:6] ddmardy_n_out)
    else $error("ready kept after stop");
  a_rdy_held: assert property (
    ddmardy_n_out && !dmarq_out && !dmack_n_in |=> ddmardy_n_out)
    else $error("ready reasserted in termination");
  a_rdy_release: assert property (
    $rose(dmack_n_in) |-> ##[1:6] !ddmardy_oe_out)
    else $error("ready not released");
  a_rp_min_gap: assert property (
    $fell(dmarq_out) && !stop_in && !dmack_n_in
      |-> hi_cnt_r >= UOC_T_RP_CYC)
    else $error("dmarq dropped too soon");
  a_done_after_burst: assert property (
    $rose(cmd_done_out) |-> dmack_n_in && !dmarq_out)
    else $error("done inside a burst");
  a_no_word_late: assert property (
    !dmarq_out && !dmack_n_in |-> !wvalid_out)
    else $error("word stored in termination");
endmodule

bind uoc_dev uoc_dev_chk u_chk (
  .core_clk_in    (core_clk_in),
  .srst_in        (srst_in),
  .dmack_n_in     (dmack_n_in),
  .stop_in        (stop_in),
  .dmarq_out      (dmarq_out),
  .ddmardy_n_out  (ddmardy_n_out),
  .ddmardy_oe_out (ddmardy_oe_out),
  .wvalid_out     (wvalid_out),
  .cmd_done_out   (cmd_done_out)
);

// ===== verification/uoc_dev_test.sv
`timescale 1ns/1ps
module uoc_dev_test
  import uoc_pkg::*;
;
  logic        clk, srst, lclk, psel, penable, pwrite, err;
  logic        pready, pslverr, dmack_n, stop, hstb;
  logic        rq, rdy_n, rdy_oe, rdy_w, wvalid, done;
  logic [7:0]  paddr;
  logic [15:0] dd, wdata, wexp;
  logic [31:0] pwdata, prdata, q, ctl;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          nwv = 0;

  // released ready line is pulled up
  assign rdy_w = rdy_oe ? rdy_n : 1'b1;

  uoc_dev dut (
    .core_clk_in(clk), .srst_in(srst), .ce_in(1'b1),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr),
    .dmack_n_in(dmack_n), .stop_in(stop), .hstrobe_in(hstb),
    .dd_in(dd), .dmarq_out(rq), .ddmardy_n_out(rdy_n),
    .ddmardy_oe_out(rdy_oe), .wdata_out(wdata), .wvalid_out(wvalid),
    .cmd_done_out(done));

  uoc_host_model host (
    .lclk_in(lclk), .dmarq_in(rq), .ddmardy_n_in(rdy_w),
    .dmack_n_out(dmack_n), .stop_out(stop), .hstrobe_out(hstb),
    .dd_out(dd));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #3;
    forever #80 lclk = ~lclk;
  end
  always @(posedge clk) begin
    if (wvalid === 1'b1) begin
      nwv  <= nwv + 1;
      wexp <= wexp + 16'h0001;
      chk("wdata", {16'h0000, wexp}, {16'h0000, wdata});
    end
  end

  // ======
  // tasks
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] x);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // waits for pready with no timeout; only the watchdog ends a hung wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    x = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    apb(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    apb(1'b0, a, 32'h0, x);
  endtask
  task automatic run(input logic [31:0] c, input int nw, input bit ht,
                     input bit bad, input int expw);
    int w0;
    w0 = nwv;
    wexp = 16'(nw * 311);
    wr(UOC_CTRL_OFS, c | 32'h1);
    host.burst(nw, ht, bad, 16'(nw * 311));
    rd(UOC_CRC_OFS, q);
    chk("crc", {host.crc_q ^ 16'(bad), host.crc_q}, q);
    chk("words", 32'(expw), 32'(nwv - w0));
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk("done", 32'h1, {31'h0, done});
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #300000;
    n_fail++;
    end_sim();
  end

  // ======
  // tests
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rd(UOC_CRC_OFS, q);
    chk("seed", {16'h0, UOC_CRC_SEED}, q & 32'hFFFF);
    apb(1'b0, 8'h14, 32'h0, q);
    chk("unmapped", 32'h1, {31'h0, err});
    $display("test reset done");
    wr(UOC_COUNT_OFS, 32'h0A);
    wr(UOC_CTRL_OFS, 32'h2);
    run(32'h0, 3, 1'b1, 1'b0, 3);
    rd(UOC_COUNT_OFS, q);
    chk("count", 32'h7, q & 32'hFFFF);
    run(32'h0, 2, 1'b1, 1'b1, 2);
    rd(UOC_STATUS_OFS, q);
    chk("icrc_abrt", 32'h8404, q & 32'h8404);
    run(32'h0, 2, 1'b1, 1'b0, 2);
    rd(UOC_STATUS_OFS, q);
    chk("err_kept", 32'h8404, q & 32'h8404);
    wr(UOC_CTRL_OFS, 32'h4);
    wait_done();
    $display("test host_term done");
    wr(UOC_CTRL_OFS, 32'h2);
    rd(UOC_STATUS_OFS, q);
    chk("err_clear", 32'h0, q & 32'h8416);
    wr(UOC_COUNT_OFS, 32'h4);
    run(32'h10, 9, 1'b0, 1'b0, 4);
    rd(UOC_STATUS_OFS, q);
    chk("no_ovr", 32'h0, q & 32'hC);
    $display("test dev_term done");
    for (int k = 1; k < 3; k++) begin
      ctl = (32'(k) << 5) | ((k == 2) ? 32'h80 : 32'h0);
      wr(UOC_SENSE_OFS, 32'h0055_6601);
      wr(UOC_COUNT_OFS, 32'h5);
      wr(UOC_CTRL_OFS, ctl | 32'h2);
      run(ctl, 2, 1'b1, 1'b1, 2);
      if (k == 1) wr(UOC_CTRL_OFS, ctl | 32'h4);
      wait_done();
      rd(UOC_STATUS_OFS, q);
      chk("chk_bit", 32'h1_0000, q & 32'h1_0000);
      rd(UOC_SENSE_OFS, q);
      chk("sense", (k == 1) ? 32'h0055_660B : 32'h0003_0804,
          q & 32'h00FF_FF0F);
      $display("test packet kind %0d done", k);
    end
    end_sim();
  end
endmodule
